//--- rtl/arcc_pkg.sv
package arcc_pkg;
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] ARCC_OFF_SC1 = 8'h00;
    localparam logic [7:0] ARCC_OFF_RES_HI = 8'h04;
    localparam logic [7:0] ARCC_OFF_RES_LO = 8'h08;
    localparam logic [7:0] ARCC_OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ARCC_OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] ARCC_OFF_CFG = 8'h14;
    // Control and configuration register field positions
    localparam int ARCC_SC1_CH_LSB = 0;
    localparam int ARCC_SC1_CONT_BIT = 5;
    localparam int ARCC_SC1_IEN_BIT = 6;
    localparam int ARCC_SC1_DONE_BIT = 7;
    localparam int ARCC_CFG_MODE_LSB = 0;
    localparam int ARCC_CFG_ASYNC_BIT = 2;
    // Reset values
    localparam logic [4:0] ARCC_CH_RESET = 5'h1f;
    localparam logic [1:0] ARCC_MODE_RESET = 2'h0;
    localparam logic [1:0] ARCC_STAT_RESET = 2'h0;
    localparam logic [1:0] ARCC_MASK_RESET = 2'h0;
    // Channel value that switches the converter off
    localparam logic [4:0] ARCC_CH_OFF = 5'h1f;
    // Result width modes
    typedef enum logic [1:0] {
        ARCC_MODE_8 = 2'h0,
        ARCC_MODE_12 = 2'h1,
        ARCC_MODE_10 = 2'h2
    } arcc_mode_e;
    // Coherency state, one-hot
    typedef enum logic [1:0] {
        ARCC_ST_OPEN = 2'h1,
        ARCC_ST_FROZEN = 2'h2
    } arcc_state_e;
    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } arcc_bus_s;
    // Converter core request to start
    typedef struct packed {
        logic start;
        logic [4:0] channel;
        logic continuous;
    } arcc_conv_s;
endpackage : arcc_pkg

//--- rtl/arcc_ctrl.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - high-byte read freezes low byte in 10/12-bit
// - 8-bit mode returns result in one byte
// - conversion end sets done flag
// - control write clears done flag, always
// - result holds latest completed conversion
// - done flag plus enable requests interrupt
// - control write selects channel and continuous mode
// - result reloads on every conversion end, in single and continuous mode alike
// - async converter clock crossed safely
module arcc_ctrl #(
    parameter int RES_W = 12
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire arcc_pkg::arcc_bus_s bus_i,
    output logic [31:0] rdata_o,
    // Converter core, bus-clock side or asynchronous side
    input wire logic conv_done_sync_i,
    input wire logic conv_done_tgl_i,
    input wire logic [RES_W-1:0] conv_data_i,
    output arcc_pkg::arcc_conv_s conv_o,
    output logic irq_o
);
    import arcc_pkg::*;

    logic [4:0] channel_reg;
    logic cont_reg;
    logic ien_reg;
    logic done_reg;
    logic [1:0] mode_reg;
    logic async_reg;
    logic [RES_W-1:0] result_reg;
    logic [7:0] lo_hold_reg;
    arcc_state_e state_reg;
    logic [1:0] stat_reg;
    logic [1:0] mask_reg;
    logic tgl_s1_reg;
    logic tgl_s2_reg;
    logic tgl_s3_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    arcc_conv_s conv_reg;

    logic sc1_wr;
    logic hi_rd;
    logic lo_rd;
    logic conv_end;
    logic [15:0] aligned;
    logic [7:0] hi_byte;
    logic [7:0] lo_byte;

    // Keep the top bits of the result for the selected width, right-justified
    function automatic logic [15:0] arcc_align(input logic [RES_W-1:0] d, input logic [1:0] m);
        logic [15:0] full;
        full = 16'(d);
        case (m)
            ARCC_MODE_8: arcc_align = {8'h00, full[RES_W-1 -: 8]};
            ARCC_MODE_10: arcc_align = {6'h00, full[RES_W-1 -: 10]};
            default: arcc_align = full;
        endcase
    endfunction : arcc_align

    // Address decode strobes
    assign sc1_wr = bus_i.wr && (bus_i.addr == ARCC_OFF_SC1);
    assign hi_rd = bus_i.rd && (bus_i.addr == ARCC_OFF_RES_HI);
    assign lo_rd = bus_i.rd && (bus_i.addr == ARCC_OFF_RES_LO);

    // clock selection
    // Async source: toggle edge after the sync pair; else direct pulse
    assign conv_end = async_reg ? (tgl_s2_reg ^ tgl_s3_reg) : conv_done_sync_i;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_s3_reg <= 1'b0;
        end else begin
            tgl_s1_reg <= conv_done_tgl_i;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            channel_reg <= ARCC_CH_RESET;
            cont_reg <= 1'b0;
            ien_reg <= 1'b0;
        end else if (sc1_wr) begin
            channel_reg <= bus_i.wdata[ARCC_SC1_CH_LSB +: 5];
            cont_reg <= bus_i.wdata[ARCC_SC1_CONT_BIT];
            ien_reg <= bus_i.wdata[ARCC_SC1_IEN_BIT];
        end
    end

    // Mode and clock source configuration
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mode_reg <= ARCC_MODE_RESET;
            async_reg <= 1'b0;
        end else if (bus_i.wr && bus_i.addr == ARCC_OFF_CFG) begin
            mode_reg <= bus_i.wdata[ARCC_CFG_MODE_LSB +: 2];
            async_reg <= bus_i.wdata[ARCC_CFG_ASYNC_BIT];
        end
    end

    // Start request to the converter core
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            conv_reg <= '0;
            conv_reg.channel <= ARCC_CH_RESET;
        end else begin
            conv_reg.start <= sc1_wr && (bus_i.wdata[ARCC_SC1_CH_LSB +: 5] != ARCC_CH_OFF);
            conv_reg.channel <= sc1_wr ? bus_i.wdata[ARCC_SC1_CH_LSB +: 5] : channel_reg;
            conv_reg.continuous <= sc1_wr ? bus_i.wdata[ARCC_SC1_CONT_BIT] : cont_reg;
        end
    end

    // Done flag
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            done_reg <= 1'b0;
        end else if (sc1_wr) begin
            done_reg <= 1'b0;
        end else if (conv_end) begin
            done_reg <= 1'b1;
        end
    end

    // Result register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            result_reg <= '0;
        end else if (conv_end) begin
            result_reg <= conv_data_i;
        end
    end

    // Aligned result split into bytes
    assign aligned = arcc_align(result_reg, mode_reg);
    assign hi_byte = aligned[15:8];
    assign lo_byte = aligned[7:0];

    // Coherency state machine
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= ARCC_ST_OPEN;
            lo_hold_reg <= 8'h00;
        end else begin
            case (state_reg)
                ARCC_ST_OPEN: begin
                    if (hi_rd && mode_reg != ARCC_MODE_8) begin
                        state_reg <= ARCC_ST_FROZEN;
                        lo_hold_reg <= lo_byte;
                    end
                end
                ARCC_ST_FROZEN: begin
                    if (lo_rd) begin
                        state_reg <= ARCC_ST_OPEN;
                    end
                end
                default: state_reg <= ARCC_ST_OPEN;
            endcase
        end
    end

    // Interrupt status, write one to clear, set wins
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            stat_reg <= ARCC_STAT_RESET;
        end else begin
            stat_reg <= (stat_reg & ~((bus_i.wr && bus_i.addr == ARCC_OFF_IRQ_STAT) ?
                bus_i.wdata[1:0] : 2'h0)) | {hi_rd && state_reg == ARCC_ST_FROZEN, conv_end};
        end
    end

    // Interrupt mask
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mask_reg <= ARCC_MASK_RESET;
        end else if (bus_i.wr && bus_i.addr == ARCC_OFF_IRQ_MASK) begin
            mask_reg <= bus_i.wdata[1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (done_reg && ien_reg) || |(stat_reg & mask_reg);
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                ARCC_OFF_SC1: rdata_reg <= {24'h0, done_reg, ien_reg, cont_reg, channel_reg};
                ARCC_OFF_RES_HI: rdata_reg <= {24'h0, mode_reg == ARCC_MODE_8 ? lo_byte : hi_byte};
                ARCC_OFF_RES_LO: rdata_reg <= {24'h0,
                    state_reg == ARCC_ST_FROZEN ? lo_hold_reg : lo_byte};
                ARCC_OFF_IRQ_STAT: rdata_reg <= {30'h0, stat_reg};
                ARCC_OFF_IRQ_MASK: rdata_reg <= {30'h0, mask_reg};
                ARCC_OFF_CFG: rdata_reg <= {29'h0, async_reg, mode_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign rdata_o = rdata_reg;
    assign irq_o = irq_reg;
    assign conv_o = conv_reg;
endmodule : arcc_ctrl

//--- sim/arcc_ctrl_asserts.sv
`timescale 1ns/1ps
module arcc_ctrl_asserts import arcc_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire arcc_bus_s bus_i,
    input wire logic [31:0] rdata_o,
    input wire logic conv_done_sync_i,
    input wire arcc_conv_s conv_o,
    input wire logic irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Control register write strobe
    logic sc1_wr;
    assign sc1_wr = bus_i.wr && bus_i.addr == ARCC_OFF_SC1;
    // Bus answers, start requests and flag clearing
    a_rdata_idle_zero: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0)
        else $error("read data not zero outside answer");
    a_unmapped_read_zero: assert property (bus_i.rd && bus_i.addr == 8'h18 |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_start_one_cycle: assert property (conv_o.start && !sc1_wr |=> !conv_o.start)
        else $error("start longer than one cycle");
    a_start_has_cause: assert property (conv_o.start |-> $past(sc1_wr && bus_i.wdata[4:0] != 5'h1f))
        else $error("start without channel write");
    a_off_no_start: assert property (sc1_wr && bus_i.wdata[4:0] == 5'h1f |=> !conv_o.start)
        else $error("start on off channel");
    a_channel_follows_write: assert property (sc1_wr |=> conv_o.channel == $past(bus_i.wdata[4:0]))
        else $error("channel not taken from write");
    a_cont_follows_write: assert property (sc1_wr |=> conv_o.continuous == $past(bus_i.wdata[5]))
        else $error("continuous not taken from write");
    a_done_clear_wins: assert property (sc1_wr ##1 !conv_done_sync_i ##1
        (bus_i.rd && bus_i.addr == ARCC_OFF_SC1) |=> !rdata_o[7])
        else $error("done flag survived control write");
    a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(bus_i.wr) || $past(bus_i.wr, 2))
        else $error("interrupt dropped without write");
    // Main scenarios reached
    c_irq: cover property (irq_o);
    c_start: cover property (conv_o.start);
    c_clash: cover property (sc1_wr && conv_done_sync_i);
endmodule : arcc_ctrl_asserts

bind arcc_ctrl arcc_ctrl_asserts i_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .conv_done_sync_i(conv_done_sync_i), .conv_o(conv_o), .irq_o(irq_o));

//--- sim/arcc_ctrl_bench.sv
`timescale 1ns/1ps
module arcc_ctrl_bench;
    import arcc_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    arcc_bus_s bus_i = '0;
    logic [31:0] rdata_o;
    logic conv_done_sync_i = 1'b0;
    logic conv_done_tgl_i = 1'b0;
    logic [11:0] conv_data_i = 12'h0;
    arcc_conv_s conv_o;
    logic irq_o;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    arcc_ctrl #(.RES_W(12)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .conv_done_sync_i(conv_done_sync_i), .conv_done_tgl_i(conv_done_tgl_i),
        .conv_data_i(conv_data_i), .conv_o(conv_o), .irq_o(irq_o));
    // Clock, 5 ns period
    initial forever #2.5 clock_i = ~clock_i;
    // Hang guard
    always @(posedge clock_i) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            finish_test();
        end
    end
    task finish_test;
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus_i.wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus_i.rd <= 1'b0;
        #1 chk(nm, e, rdata_o);
    endtask : rd
    // One finished conversion on the bus-clock path
    task conv(input logic [11:0] d);
        @(posedge clock_i);
        conv_data_i <= d;
        conv_done_sync_i <= 1'b1;
        @(posedge clock_i);
        conv_done_sync_i <= 1'b0;
    endtask : conv
    task t_reset;
        rd(ARCC_OFF_SC1, 32'h1f, "sc1");
        rd(ARCC_OFF_CFG, 32'h0, "cfg");
        rd(8'h18, 32'h0, "unmapped");
    endtask : t_reset
    task t_mode8;
        wr(ARCC_OFF_SC1, 32'h43);
        conv(12'habc);
        @(posedge clock_i);
        #1 chk("irq", 32'h1, {31'h0, irq_o});
        rd(ARCC_OFF_SC1, 32'hc3, "sc1");
        rd(ARCC_OFF_RES_HI, 32'hab, "hi");
        wr(ARCC_OFF_SC1, 32'h1f);
        rd(ARCC_OFF_SC1, 32'h1f, "sc1");
        chk("irq", 32'h0, {31'h0, irq_o});
    endtask : t_mode8
    // Control write in the same cycle as a completion
    task t_clash;
        @(posedge clock_i);
        bus_i <= '{addr: ARCC_OFF_SC1, wdata: 32'h1f, wr: 1'b1, rd: 1'b0};
        conv_done_sync_i <= 1'b1;
        @(posedge clock_i);
        bus_i.wr <= 1'b0;
        conv_done_sync_i <= 1'b0;
        rd(ARCC_OFF_SC1, 32'h1f, "sc1");
    endtask : t_clash
    task t_mode12;
        wr(ARCC_OFF_CFG, 32'h1);
        conv(12'h5a7);
        rd(ARCC_OFF_RES_HI, 32'h5, "hi");
        conv(12'h3c4);
        rd(ARCC_OFF_RES_LO, 32'ha7, "lo");
        rd(ARCC_OFF_RES_HI, 32'h3, "hi");
        rd(ARCC_OFF_RES_LO, 32'hc4, "lo");
        wr(ARCC_OFF_CFG, 32'h2);
        conv(12'h9b4);
        rd(ARCC_OFF_RES_HI, 32'h2, "hi");
        conv(12'h000);
        rd(ARCC_OFF_RES_LO, 32'h6d, "lo");
    endtask : t_mode12
    task t_irq;
        wr(ARCC_OFF_IRQ_MASK, 32'h1);
        rd(ARCC_OFF_RES_HI, 32'h0, "hi");
        rd(ARCC_OFF_RES_HI, 32'h0, "hi");
        rd(ARCC_OFF_IRQ_STAT, 32'h3, "stat");
        chk("irq", 32'h1, {31'h0, irq_o});
        rd(ARCC_OFF_RES_LO, 32'h0, "lo");
        wr(ARCC_OFF_IRQ_STAT, 32'h3);
        rd(ARCC_OFF_IRQ_STAT, 32'h0, "stat");
        chk("irq", 32'h0, {31'h0, irq_o});
    endtask : t_irq
    // Completion through the toggle path
    task t_async;
        wr(ARCC_OFF_CFG, 32'h4);
        @(posedge clock_i);
        conv_data_i <= 12'h7e0;
        conv_done_tgl_i <= ~conv_done_tgl_i;
        repeat (8) @(posedge clock_i);
        rd(ARCC_OFF_RES_HI, 32'h7e, "hi");
    endtask : t_async
    // Main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_mode8();
        t_clash();
        t_mode12();
        t_irq();
        t_async();
        finish_test();
    end
endmodule : arcc_ctrl_bench
